// ### shared/burst_sram_pkg.sv
package burst_sram_pkg;

  // Lane and bus geometry
  localparam int LANE_W = 9;
  localparam int DATA_W_DEF = 18;
  localparam int ADDR_W_DEF = 21;
  localparam int BURST_LEN = 2;

  // Read pipeline depth in link cycles after the command edge
  localparam int RD_PIPE = 3;
  localparam int WR_PIPE = 2;

  // System clock and link divider
  localparam int CLK_MHZ = 100;
  localparam int K_DIV_DEF = 2;
  localparam int BYPASS_MAX_MHZ = 167;

  // Direction select encoding while the load strobe is low
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;

  // Values after reset or with nothing driving
  localparam logic TERM_FLOAT_DEFAULT = 1'b1;
  localparam logic LOAD_IDLE_N = 1'b1;
  localparam logic PLL_ON_N = 1'b1;

  // Controller sequencing
  typedef enum {
    C_IDLE,
    C_PEND,
    C_CMD,
    C_WB1,
    C_WEND,
    C_RWAIT
  } ctl_state_t;

endpackage : burst_sram_pkg

// ### shared/burst_link_if.sv
`timescale 1ns/1ps
interface burst_link_if #(
  parameter int DW = 18,
  parameter int AW = 21
);
  // Clocks made by the controller
  logic k;
  logic k_n;
  // Command group
  logic load_strobe_n;
  logic rw;
  logic [AW-1:0] addr;
  logic [DW/9-1:0] byte_write_select_n;
  // Shared data bus, one driver set per end
  logic [DW-1:0] ctl_dq;
  logic ctl_dq_oe;
  logic [DW-1:0] dev_dq;
  logic dev_dq_oe;
  logic [DW-1:0] dq;
  // Device timing outputs
  logic echo_timing_out;
  logic echo_timing_out_n;
  logic output_valid_flag;
  // Straps
  logic term_o;
  logic term_oe;
  logic termination_range_select;
  logic pll_bypass_n;

  // Wire level of the shared pins; an undriven strap floats high
  assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);
  assign termination_range_select = term_oe ? term_o : 1'b1;

  modport dev (
    input k, k_n, load_strobe_n, rw, addr, byte_write_select_n, dq,
    input termination_range_select, pll_bypass_n,
    output dev_dq, dev_dq_oe, echo_timing_out, echo_timing_out_n, output_valid_flag
  );

  modport ctl (
    output k, k_n, load_strobe_n, rw, addr, byte_write_select_n, ctl_dq, ctl_dq_oe,
    output term_o, term_oe, pll_bypass_n,
    input dq, output_valid_flag, echo_timing_out, echo_timing_out_n
  );
endinterface : burst_link_if

// ### rtl/burst_sram_dev.sv
// What this block does
// - Accesses start at true-clock rising edges.
// - Low load strobe defines transaction, address, direction.
// - Every transaction moves exactly two words.
// - Select high reads, low writes loaded address.
// - One shared address bus, sampled at command.
// - Write beats captured on both input clocks.
// - Read beats driven on both input clocks.
// - Data outputs released when no read runs.
// - Each active-low byte select covers nine bits.
// - Byte selects sampled with their data beat.
// - Deselected byte leaves stored byte unchanged.
// - Valid flag marks read data, echo-aligned.
// - True edge captures inputs, launches read data.
// - Complement edge takes second write beat, launches first read beat (second in bypass).
// - Termination range latched at init, float high.
// - Echo clocks free-run, following input clock.
// - Bypass strap low selects legacy one-cycle mode.
`timescale 1ns/1ps
module burst_sram_dev
  import burst_sram_pkg::*;
#(
  parameter int DW = DATA_W_DEF,
  parameter int AW = ADDR_W_DEF
) (
  // System side
  input wire logic i_clk,
  input wire logic i_rst,
  // Link side
  burst_link_if.dev link,
  // Straps seen from the system side
  output logic o_term_high_q,
  output logic o_bypass_q
);

  localparam int NL = DW / LANE_W;
  localparam int DEPTH = 2 ** (AW + 1);

  logic [1:0] krst_q;
  logic rst_k;
  logic init_done_q;
  logic term_q;
  logic byp_q;
  logic cmd_rd;
  logic cmd_wr;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] wa1_q;
  logic [RD_PIPE-1:0] rd_sh_q;
  logic [WR_PIPE-1:0] wr_sh_q;
  logic [DW-1:0] word0_w;
  logic [DW-1:0] word1_w;
  logic [DW-1:0] rw0_q;
  logic [DW-1:0] rw1_q;
  logic [DW-1:0] rx0_q;
  logic [DW-1:0] rx1_q;
  logic [DW-1:0] kq_data_q;
  logic kq_vld_q;
  logic [DW-1:0] kbq_data_q;
  logic kbq_vld_q;
  logic [DW-1:0] wb_data_q;
  logic [NL-1:0] wb_sel_n_q;
  logic [1:0] term_sync_q;
  logic [1:0] byp_sync_q;

  // Link-side reset: asserts at once, releases on a true edge
  always_ff @(posedge link.k or posedge i_rst) begin
    if (i_rst) begin
      krst_q <= 2'b11;
    end else begin
      krst_q <= {krst_q[0], 1'b0};
    end
  end
  assign rst_k = krst_q[1];

  // Straps caught once, on the first link edge after reset
  always_ff @(posedge link.k or posedge rst_k) begin
    if (rst_k) begin
      init_done_q <= 1'b0;
      term_q <= TERM_FLOAT_DEFAULT;
      byp_q <= 1'b0;
    end else if (!init_done_q) begin
      init_done_q <= 1'b1;
      term_q <= link.termination_range_select;
      byp_q <= !link.pll_bypass_n;
    end
  end

  // Straps carried over to the system clock, three stages each
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      term_sync_q <= 2'b00;
      byp_sync_q <= 2'b00;
      o_term_high_q <= 1'b0;
      o_bypass_q <= 1'b0;
    end else begin
      term_sync_q <= {term_sync_q[0], term_q};
      byp_sync_q <= {byp_sync_q[0], byp_q};
      o_term_high_q <= term_sync_q[1];
      o_bypass_q <= byp_sync_q[1];
    end
  end

  // Command decode; ignored until the straps are caught
  assign cmd_rd = init_done_q && !link.load_strobe_n && (link.rw == RW_READ);
  assign cmd_wr = init_done_q && !link.load_strobe_n && (link.rw == RW_WRITE);

  // Address and direction taken only at a true rising edge
  always_ff @(posedge link.k) begin
    if (!link.load_strobe_n) begin
      addr_q <= link.addr;
    end
    if (wr_sh_q[0]) begin
      wa1_q <= addr_q;
    end
  end

  // Per-transaction pipelines; each command fires a fixed two-beat schedule
  always_ff @(posedge link.k or posedge rst_k) begin
    if (rst_k) begin
      rd_sh_q <= '0;
      wr_sh_q <= '0;
    end else begin
      rd_sh_q <= {rd_sh_q[RD_PIPE-2:0], cmd_rd};
      wr_sh_q <= {wr_sh_q[WR_PIPE-2:0], cmd_wr};
    end
  end

  // Storage, one array per lane so that each lane writes alone
  for (genvar l = 0; l < NL; l++) begin : g_lane
    logic [LANE_W-1:0] mem [DEPTH];

    // Both beats are written on true edges so the array has one clock
    always_ff @(posedge link.k) begin
      if (wr_sh_q[0] && !link.byte_write_select_n[l]) begin
        mem[{addr_q, 1'b0}] <= link.dq[l*LANE_W +: LANE_W];
      end
      if (wr_sh_q[1] && !wb_sel_n_q[l]) begin
        mem[{wa1_q, 1'b1}] <= wb_data_q[l*LANE_W +: LANE_W];
      end
    end

    assign word0_w[l*LANE_W +: LANE_W] = mem[{addr_q, 1'b0}];
    assign word1_w[l*LANE_W +: LANE_W] = mem[{addr_q, 1'b1}];
  end

  // Second write beat and its selects, caught on the complement edge.
  // Stage one has already shifted on by then, so stage two qualifies it.
  always_ff @(posedge link.k_n or posedge rst_k) begin
    if (rst_k) begin
      wb_data_q <= '0;
      wb_sel_n_q <= '1;
    end else if (wr_sh_q[1]) begin
      wb_data_q <= link.dq;
      wb_sel_n_q <= link.byte_write_select_n;
    end
  end

  // Read words fetched one cycle after the command, then held one more
  always_ff @(posedge link.k or posedge rst_k) begin
    if (rst_k) begin
      rw0_q <= '0;
      rw1_q <= '0;
      rx0_q <= '0;
      rx1_q <= '0;
    end else begin
      if (rd_sh_q[0]) begin
        rw0_q <= word0_w;
        rw1_q <= word1_w;
      end
      // Second copy lets a read follow every cycle without overwrite
      if (rd_sh_q[1]) begin
        rx0_q <= rw0_q;
        rx1_q <= rw1_q;
      end
    end
  end

  // True-edge launch: first beat when bypassed, else the second beat
  always_ff @(posedge link.k or posedge rst_k) begin
    if (rst_k) begin
      kq_vld_q <= 1'b0;
      kq_data_q <= '0;
    end else if (byp_q) begin
      kq_vld_q <= rd_sh_q[0];
      kq_data_q <= word0_w;
    end else begin
      kq_vld_q <= rd_sh_q[2];
      kq_data_q <= rx1_q;
    end
  end

  // Complement-edge launch: second beat when bypassed, else the first, half a cycle before the true-edge beat
  always_ff @(posedge link.k_n or posedge rst_k) begin
    if (rst_k) begin
      kbq_vld_q <= 1'b0;
      kbq_data_q <= '0;
    end else if (byp_q) begin
      kbq_vld_q <= rd_sh_q[1];
      kbq_data_q <= rw1_q;
    end else begin
      kbq_vld_q <= rd_sh_q[2];
      kbq_data_q <= rx0_q;
    end
  end

  // Bus side: the clock level picks which launch register is on the pins.
  // A mux on the clock is the usual double-rate output; it keeps both
  // halves from flip-flops and ties valid to the echo edges exactly.
  assign link.dev_dq_oe = link.k ? kq_vld_q : kbq_vld_q;
  assign link.dev_dq = link.k ? kq_data_q : kbq_data_q;
  assign link.output_valid_flag = link.k ? kq_vld_q : kbq_vld_q;

  // Echo clocks follow the input pair with no gating
  assign link.echo_timing_out = link.k;
  assign link.echo_timing_out_n = link.k_n;

endmodule : burst_sram_dev

// ### rtl/burst_sram_ctl.sv
`timescale 1ns/1ps
module burst_sram_ctl
  import burst_sram_pkg::*;
#(
  parameter int DW = DATA_W_DEF,
  parameter int AW = ADDR_W_DEF,
  parameter int K_DIV = K_DIV_DEF
) (
  // System side
  input wire logic i_clk,
  input wire logic i_rst,
  // Request
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata0,
  input wire logic [DW-1:0] i_wdata1,
  input wire logic [DW/9-1:0] i_be0,
  input wire logic [DW/9-1:0] i_be1,
  // Straps
  input wire logic i_term_high,
  input wire logic i_term_float,
  input wire logic i_pll_bypass,
  // Answer
  output logic o_busy_q,
  output logic o_wdone_q,
  output logic o_rvalid_q,
  output logic [DW-1:0] o_rdata0_q,
  output logic [DW-1:0] o_rdata1_q,
  // Link side
  burst_link_if.ctl link
);

  localparam int NL = DW / LANE_W;
  localparam int PHW = $clog2(2 * K_DIV) + 1;
  localparam logic [PHW-1:0] PH_LAST = PHW'(2 * K_DIV - 1);
  localparam logic [PHW-1:0] PH_FALL = PHW'(K_DIV - 1);
  localparam logic [PHW-1:0] TICK_H = PHW'(K_DIV / 2 - 1);
  localparam logic [PHW-1:0] TICK_L = PHW'(K_DIV + K_DIV / 2 - 1);
  localparam logic [PHW:0] CAP0 = (PHW+1)'(K_DIV / 2);
  localparam logic [PHW:0] CAP1 = (PHW+1)'(K_DIV + K_DIV / 2);

  ctl_state_t state_q;
  logic [PHW-1:0] ph_q;
  logic k_q;
  logic tick_h;
  logic tick_l;
  logic wr_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wd0_q;
  logic [DW-1:0] wd1_q;
  logic [NL-1:0] be0_q;
  logic [NL-1:0] be1_q;
  logic strobe_n_q;
  logic rw_q;
  logic [AW-1:0] la_q;
  logic [NL-1:0] lane_sel_n_q;
  logic [DW-1:0] dq_q;
  logic dq_oe_q;
  logic [1:0] vld_sync_q;
  logic [DW-1:0] dq_sync0_q;
  logic [DW-1:0] dq_sync1_q;
  logic seen_q;
  logic [PHW:0] cap_q;
  logic term_o_q;
  logic term_oe_q;
  logic byp_n_q;

  // Link clock from a divider; K_DIV system cycles per half period
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_q <= '0;
      k_q <= 1'b1;
    end else begin
      ph_q <= (ph_q == PH_LAST) ? '0 : ph_q + PHW'(1);
      if (ph_q == PH_FALL) begin
        k_q <= 1'b0;
      end else if (ph_q == PH_LAST) begin
        k_q <= 1'b1;
      end
    end
  end
  // Changes land mid-phase, clear of either clock edge
  assign tick_h = (ph_q == TICK_H);
  assign tick_l = (ph_q == TICK_L);

  // Strap drive, registered from the user inputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      term_o_q <= TERM_FLOAT_DEFAULT;
      term_oe_q <= 1'b0;
      byp_n_q <= PLL_ON_N;
    end else begin
      term_o_q <= i_term_high;
      term_oe_q <= !i_term_float;
      byp_n_q <= !i_pll_bypass;
    end
  end

  // Read return passes two stages before any use
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vld_sync_q <= 2'b00;
      dq_sync0_q <= '0;
      dq_sync1_q <= '0;
    end else begin
      vld_sync_q <= {vld_sync_q[0], link.output_valid_flag};
      dq_sync0_q <= link.dq;
      dq_sync1_q <= dq_sync0_q;
    end
  end

  // Transaction sequencer; one request at a time, no overlap of bursts
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= C_IDLE;
      wr_q <= 1'b0;
      addr_q <= '0;
      wd0_q <= '0;
      wd1_q <= '0;
      be0_q <= '0;
      be1_q <= '0;
      strobe_n_q <= LOAD_IDLE_N;
      rw_q <= RW_READ;
      la_q <= '0;
      lane_sel_n_q <= '1;
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      o_busy_q <= 1'b0;
      o_wdone_q <= 1'b0;
      o_rvalid_q <= 1'b0;
      o_rdata0_q <= '0;
      o_rdata1_q <= '0;
      seen_q <= 1'b0;
      cap_q <= '0;
    end else begin
      o_wdone_q <= 1'b0;
      o_rvalid_q <= 1'b0;
      unique case (state_q)
        C_IDLE: begin
          if (i_req) begin
            wr_q <= i_write;
            addr_q <= i_addr;
            wd0_q <= i_wdata0;
            wd1_q <= i_wdata1;
            be0_q <= i_be0;
            be1_q <= i_be1;
            o_busy_q <= 1'b1;
            state_q <= C_PEND;
          end
        end
        C_PEND: begin
          if (tick_l) begin
            strobe_n_q <= 1'b0;
            rw_q <= wr_q ? RW_WRITE : RW_READ;
            la_q <= addr_q;
            state_q <= C_CMD;
          end
        end
        C_CMD: begin
          if (tick_h) begin
            strobe_n_q <= LOAD_IDLE_N;
            seen_q <= 1'b0;
            if (wr_q) begin
              dq_q <= wd0_q;
              lane_sel_n_q <= ~be0_q;
              dq_oe_q <= 1'b1;
              state_q <= C_WB1;
            end else begin
              state_q <= C_RWAIT;
            end
          end
        end
        C_WB1: begin
          if (tick_h) begin
            dq_q <= wd1_q;
            lane_sel_n_q <= ~be1_q;
            state_q <= C_WEND;
          end
        end
        C_WEND: begin
          if (tick_l) begin
            dq_oe_q <= 1'b0;
            lane_sel_n_q <= '1;
            o_busy_q <= 1'b0;
            o_wdone_q <= 1'b1;
            state_q <= C_IDLE;
          end
        end
        C_RWAIT: begin
          // Sample each beat at its middle, counted from first valid
          if (!seen_q) begin
            if (vld_sync_q[1]) begin
              seen_q <= 1'b1;
              cap_q <= (PHW+1)'(1);
            end
          end else begin
            cap_q <= cap_q + (PHW+1)'(1);
            if (cap_q == CAP0) begin
              o_rdata0_q <= dq_sync1_q;
            end
            if (cap_q == CAP1) begin
              o_rdata1_q <= dq_sync1_q;
              o_rvalid_q <= 1'b1;
              o_busy_q <= 1'b0;
              state_q <= C_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Link pins straight from flip-flops; k_n is the inverse of k_q
  assign link.k = k_q;
  assign link.k_n = !k_q;
  assign link.load_strobe_n = strobe_n_q;
  assign link.rw = rw_q;
  assign link.addr = la_q;
  assign link.byte_write_select_n = lane_sel_n_q;
  assign link.ctl_dq = dq_q;
  assign link.ctl_dq_oe = dq_oe_q;
  assign link.term_o = term_o_q;
  assign link.term_oe = term_oe_q;
  assign link.pll_bypass_n = byp_n_q;

endmodule : burst_sram_ctl

// ### bench/burst_link_chk.sv
`timescale 1ns/1ps
module burst_link_chk
  import burst_sram_pkg::*;
#(
  parameter int DW = DATA_W_DEF
) (
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic k,
  input wire logic k_n,
  // Command and data enables
  input wire logic load_strobe_n,
  input wire logic rw,
  input wire logic [DW/9-1:0] byte_write_select_n,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe,
  // Device timing outputs and strap
  input wire logic echo_timing_out,
  input wire logic echo_timing_out_n,
  input wire logic output_valid_flag,
  input wire logic pll_bypass_n
);
  // Level checks on the system clock, which also makes k
  clk_pair_a: assert property (@(posedge i_clk) disable iff (i_rst)
    k_n == !k) else $error("link clock pair not complementary");
  echo_track_a: assert property (@(posedge i_clk) disable iff (i_rst)
    echo_timing_out == k && echo_timing_out_n == k_n) else $error("echo clock off");
  valid_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
    output_valid_flag == dev_dq_oe) else $error("valid flag not with read drive");
  // Valid may only move when the echo clock moves
  valid_edge_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(output_valid_flag) |-> $changed(echo_timing_out)) else $error("valid off echo edge");
  no_contend_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !(dev_dq_oe && ctl_dq_oe)) else $error("both ends drive the data bus");
  lane_sel_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !ctl_dq_oe |-> &byte_write_select_n) else $error("byte select low without data");
  // Burst framing seen at true-clock rising edges
  strobe_once_a: assert property (@(posedge k) disable iff (i_rst)
    !load_strobe_n |=> load_strobe_n) else $error("load strobe held past one edge");
  rd_pll_a: assert property (@(posedge k) disable iff (i_rst)
    (!load_strobe_n && rw == RW_READ && pll_bypass_n) |-> ##1 !output_valid_flag [*2]
    ##1 output_valid_flag ##1 !output_valid_flag) else $error("read latency wrong");
  rd_bypass_a: assert property (@(posedge k) disable iff (i_rst)
    (!load_strobe_n && rw == RW_READ && !pll_bypass_n) |-> ##1 !output_valid_flag
    ##1 output_valid_flag ##1 !output_valid_flag) else $error("bypass latency wrong");
  wr_beats_a: assert property (@(posedge k) disable iff (i_rst)
    (!load_strobe_n && rw == RW_WRITE) |-> ##1 (ctl_dq_oe && !dev_dq_oe)
    ##1 (!ctl_dq_oe && !output_valid_flag)) else $error("write burst framing wrong");
endmodule : burst_link_chk

// ### bench/dual_edge_burst_sram_port_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end
module dual_edge_burst_sram_port_tb_top;
  import burst_sram_pkg::*;
  localparam int DW = DATA_W_DEF;
  localparam int AW = 6;
  localparam int NL = DW / LANE_W;
  // Stimulus and observed outputs
  logic i_clk, i_rst, i_req, i_write, i_term_high, i_term_float, i_pll_bypass;
  logic [AW-1:0] i_addr;
  logic [DW-1:0] i_wdata0, i_wdata1, o_rdata0_q, o_rdata1_q;
  logic [NL-1:0] i_be0, i_be1;
  logic o_busy_q, o_wdone_q, o_rvalid_q, o_term_high_q, o_bypass_q;
  // Reference memory by word and the expected-result queue
  logic [DW-1:0] mem [logic [AW:0]];
  logic [2*DW:0] exp_q [$];
  int bad_count;
  int check_count;

  burst_link_if #(.DW(DW), .AW(AW)) link ();

  burst_sram_ctl #(.DW(DW), .AW(AW)) i_burst_sram_ctl (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_write(i_write), .i_addr(i_addr),
    .i_wdata0(i_wdata0), .i_wdata1(i_wdata1), .i_be0(i_be0), .i_be1(i_be1),
    .i_term_high(i_term_high), .i_term_float(i_term_float), .i_pll_bypass(i_pll_bypass),
    .o_busy_q(o_busy_q), .o_wdone_q(o_wdone_q), .o_rvalid_q(o_rvalid_q),
    .o_rdata0_q(o_rdata0_q), .o_rdata1_q(o_rdata1_q), .link(link));

  burst_sram_dev #(.DW(DW), .AW(AW)) i_burst_sram_dev (
    .i_clk(i_clk), .i_rst(i_rst), .link(link),
    .o_term_high_q(o_term_high_q), .o_bypass_q(o_bypass_q));

  burst_link_chk #(.DW(DW)) i_burst_link_chk (
    .i_clk(i_clk), .i_rst(i_rst), .k(link.k), .k_n(link.k_n),
    .load_strobe_n(link.load_strobe_n), .rw(link.rw),
    .byte_write_select_n(link.byte_write_select_n), .ctl_dq_oe(link.ctl_dq_oe),
    .dev_dq_oe(link.dev_dq_oe), .echo_timing_out(link.echo_timing_out),
    .echo_timing_out_n(link.echo_timing_out_n),
    .output_valid_flag(link.output_valid_flag), .pll_bypass_n(link.pll_bypass_n));

  // System clock, 100 MHz
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // One burst request; the model is updated before issue, so reads see prior writes
  task automatic op(input logic wr, input logic [AW-1:0] a, input logic [NL-1:0] b0, b1);
    logic [DW-1:0] w0;
    logic [DW-1:0] w1;
    int n;
    w0 = DW'($urandom);
    w1 = DW'($urandom);
    if (wr) begin
      for (int l = 0; l < NL; l++) begin
        if (b0[l]) mem[{a, 1'b0}][l*LANE_W +: LANE_W] = w0[l*LANE_W +: LANE_W];
        if (b1[l]) mem[{a, 1'b1}][l*LANE_W +: LANE_W] = w1[l*LANE_W +: LANE_W];
      end
      exp_q.push_back('0);
    end else begin
      exp_q.push_back({1'b1, mem[{a, 1'b1}], mem[{a, 1'b0}]});
    end
    @(posedge i_clk);
    i_req <= 1'b1;
    i_write <= wr;
    i_addr <= a;
    i_wdata0 <= w0;
    i_wdata1 <= w1;
    i_be0 <= b0;
    i_be1 <= b1;
    @(posedge i_clk);
    i_req <= 1'b0;
    n = 0;
    // Bounded wait; a stuck busy counts as a mismatch
    do begin
      @(posedge i_clk);
      n++;
    end while (o_busy_q !== 1'b0 && n < 400);
    if (n >= 400) bad_count++;
  endtask : op

  // Straps only latch at reset, so each strap set needs its own reset
  task automatic phase(input logic fl, input logic hi, input logic byp);
    logic [AW-1:0] a;
    i_term_float <= fl;
    i_term_high <= hi;
    i_pll_bypass <= byp;
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    mem.delete();
    repeat (40) @(posedge i_clk);
    `CHK("term_high", fl ? TERM_FLOAT_DEFAULT : hi, o_term_high_q)
    `CHK("bypass", byp, o_bypass_q)
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? '1 : (i == 1) ? '0 : AW'($urandom);
      op(1'b1, a, '1, '1);
      op(1'b1, a, NL'($urandom), NL'($urandom));
      op(1'b1, a ^ AW'(1), '1, '1);
      op(1'b0, a, '0, '0);
      op(1'b0, a, '0, '0);
    end
    $display("test strap set float=%0b high=%0b bypass=%0b done", fl, hi, byp);
  endtask : phase

  // Result watcher: each answer pulse retires the oldest expectation
  always @(posedge i_clk) begin
    logic [2*DW:0] e;
    if (o_wdone_q === 1'b1 || o_rvalid_q === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 'x;
      `CHK("kind", e[2*DW], o_rvalid_q)
      if (e[2*DW]) `CHK("rdata", e[2*DW-1:0], {o_rdata1_q, o_rdata0_q})
    end
  end

  // Main sequence; the second and third sets reset the pair in mid-run
  initial begin
    i_rst = 1'b1;
    i_req = 1'b0;
    i_write = 1'b0;
    i_addr = '0;
    i_wdata0 = '0;
    i_wdata1 = '0;
    i_be0 = '0;
    i_be1 = '0;
    i_term_float = 1'b1;
    i_term_high = 1'b0;
    i_pll_bypass = 1'b0;
    bad_count = 0;
    check_count = 0;
    void'($urandom(29075));
    phase(1'b1, 1'b0, 1'b0);
    phase(1'b0, 1'b0, 1'b1);
    phase(1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge i_clk);
    complete_run();
  end

  // Watchdog: the run needs about 2k cycles, so 50k means a hang
  initial begin
    #500000;
    bad_count++;
    complete_run();
  end
endmodule : dual_edge_burst_sram_port_tb_top
